/* design/aigrc_defs.svh */
// Offsets, register indices, field codes, reset values and timing counts for the config bank
`ifndef AIGRC_DEFS_SVH
`define AIGRC_DEFS_SVH
`define AIGRC_IDX_INPUT_SELECT   8'h02
`define AIGRC_IDX_GAIN_SETTING   8'h03
`define AIGRC_IDX_RATE_CONFIG    8'h04
`define AIGRC_IDX_CONV_STATUS    8'h05
`define AIGRC_ADR_INPUT_SELECT   8'h08
`define AIGRC_ADR_GAIN_SETTING   8'h0c
`define AIGRC_ADR_RATE_CONFIG    8'h10
`define AIGRC_ADR_CONV_STATUS    8'h14
`define AIGRC_RST_INPUT_SELECT   8'h01
`define AIGRC_RST_GAIN_SETTING   8'h00
`define AIGRC_RST_RATE_CONFIG    8'h14
`define AIGRC_CODE_COMMON_INPUT  4'hc
`define AIGRC_AMP_BYPASS         2'h0
`define AIGRC_AMP_ENABLED        2'h1
`define AIGRC_DLY_CODE0          13'h000e
`define AIGRC_DLY_CODE1          13'h0019
`define AIGRC_DLY_CODE2          13'h0040
`define AIGRC_DLY_CODE3          13'h0100
`define AIGRC_DLY_CODE4          13'h0400
`define AIGRC_DLY_CODE5          13'h0800
`define AIGRC_DLY_CODE6          13'h1000
`define AIGRC_DLY_CODE7          13'h0001
`endif

/* design/aigrc_pkg.sv */
// Types shared by the config bank files
package aigrc_pkg;
    typedef struct packed {
        logic [3:0] positive_input_sel;
        logic [3:0] negative_input_sel;
    } aigrc_input_type;
    typedef struct packed {
        logic [2:0] start_delay_code;
        logic [1:0] amp_enable_field;
        logic [2:0] gain_code;
    } aigrc_gain_type;
    typedef struct packed {
        logic       global_chop_en;
        logic       clock_source_ext;
        logic       single_shot_mode;
        logic       low_latency_filter;
        logic [3:0] output_rate_code;
    } aigrc_rate_type;
    typedef struct packed {
        logic        positive_is_common;
        logic        negative_is_common;
        logic        positive_reserved;
        logic        negative_reserved;
        logic        amp_enabled;
        logic        amp_reserved;
        logic [7:0]  gain_factor;
    } aigrc_decode_type;
endpackage

/* design/aigrc_regs.sv */
// Input, gain and rate configuration registers on a classic Wishbone slave
`timescale 1ns/10ps
`include "aigrc_defs.svh"
module aigrc_regs
    import aigrc_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Modulator clock enable
    input  wire logic                      mod_tick,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Configuration outputs
    output aigrc_pkg::aigrc_input_type     input_cfg,
    output aigrc_pkg::aigrc_gain_type      gain_cfg,
    output aigrc_pkg::aigrc_rate_type      rate_cfg,
    output aigrc_pkg::aigrc_decode_type    decode_cfg,
    // Conversion control
    output logic                           filter_restart,
    output logic                           start_conv,
    output logic                           delay_busy
);
    import aigrc_pkg::*;

    aigrc_input_type  input_select_r;
    aigrc_gain_type   gain_setting_r;
    aigrc_rate_type   rate_config_r;
    logic             ack_r;
    logic [31:0]      rdata_r;
    logic             restart_r;
    logic             req;
    logic             wr_lane0;
    logic [7:0]       wbyte;
    logic [7:0]       rd_mux;

    assign req      = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    assign wbyte    = wb_dat_i[7:0];

    // Ack one cycle after request, dropped the next cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end
    assign wb_ack_o = ack_r;

    // Input select register
    always_ff @(posedge clk) begin
        if (reset) begin
            input_select_r <= `AIGRC_RST_INPUT_SELECT;
        end else if (wr_lane0 && wb_adr_i == `AIGRC_ADR_INPUT_SELECT) begin
            input_select_r <= wbyte;
        end
    end

    // Gain setting register
    always_ff @(posedge clk) begin
        if (reset) begin
            gain_setting_r <= `AIGRC_RST_GAIN_SETTING;
        end else if (wr_lane0 && wb_adr_i == `AIGRC_ADR_GAIN_SETTING) begin
            gain_setting_r <= wbyte;
        end
    end

    // Rate configuration register
    always_ff @(posedge clk) begin
        if (reset) begin
            rate_config_r <= `AIGRC_RST_RATE_CONFIG;
        end else if (wr_lane0 && wb_adr_i == `AIGRC_ADR_RATE_CONFIG) begin
            rate_config_r <= wbyte;
        end
    end

    // Any write to the bank that changes a value restarts the filter
    always_ff @(posedge clk) begin
        if (reset) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_lane0 && (
                (wb_adr_i == `AIGRC_ADR_INPUT_SELECT && wbyte != input_select_r) ||
                (wb_adr_i == `AIGRC_ADR_GAIN_SETTING && wbyte != gain_setting_r) ||
                (wb_adr_i == `AIGRC_ADR_RATE_CONFIG && wbyte != rate_config_r));
        end
    end
    assign filter_restart = restart_r;

    aigrc_start_delay u_start_delay (
        .clk        (clk),
        .reset      (reset),
        .mod_tick   (mod_tick),
        .restart    (restart_r),
        .delay_code (gain_setting_r.start_delay_code),
        .delay_busy (delay_busy),
        .start_conv (start_conv)
    );

    // Read mux
    always_comb begin
        rd_mux = 8'h00;
        if (wb_adr_i == `AIGRC_ADR_INPUT_SELECT) begin
            rd_mux = input_select_r;
        end else if (wb_adr_i == `AIGRC_ADR_GAIN_SETTING) begin
            rd_mux = gain_setting_r;
        end else if (wb_adr_i == `AIGRC_ADR_RATE_CONFIG) begin
            rd_mux = rate_config_r;
        end else if (wb_adr_i == `AIGRC_ADR_CONV_STATUS) begin
            rd_mux = {7'h00, delay_busy};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_r <= {24'h00_0000, rd_mux};
        end
    end
    assign wb_dat_o = rdata_r;

    // Field decode
    always_ff @(posedge clk) begin
        if (reset) begin
            decode_cfg <= '0;
        end else begin
            decode_cfg.positive_is_common <=
                input_select_r.positive_input_sel == `AIGRC_CODE_COMMON_INPUT;
            decode_cfg.negative_is_common <=
                input_select_r.negative_input_sel == `AIGRC_CODE_COMMON_INPUT;
            decode_cfg.positive_reserved <=
                input_select_r.positive_input_sel > `AIGRC_CODE_COMMON_INPUT;
            decode_cfg.negative_reserved <=
                input_select_r.negative_input_sel > `AIGRC_CODE_COMMON_INPUT;
            decode_cfg.amp_enabled <=
                gain_setting_r.amp_enable_field == `AIGRC_AMP_ENABLED;
            decode_cfg.amp_reserved <=
                gain_setting_r.amp_enable_field[1];
            decode_cfg.gain_factor <= 8'h01 << gain_setting_r.gain_code;
        end
    end

    assign input_cfg = input_select_r;
    assign gain_cfg  = gain_setting_r;
    assign rate_cfg  = rate_config_r;

    AST_RESET_VALUES: assert property (@(posedge clk)
        $fell(reset) |-> input_select_r == `AIGRC_RST_INPUT_SELECT
                         && gain_setting_r == `AIGRC_RST_GAIN_SETTING
                         && rate_config_r == `AIGRC_RST_RATE_CONFIG)
        else $error("bad reset values");
    AST_ACK_ONE: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    AST_WRITE_BACK: assert property (@(posedge clk) disable iff (reset)
        (wr_lane0 && wb_adr_i == `AIGRC_ADR_RATE_CONFIG) |=> rate_config_r == $past(wbyte))
        else $error("rate write lost");
    AST_READ_BACK: assert property (@(posedge clk) disable iff (reset)
        (req && !wb_we_i && wb_adr_i == `AIGRC_ADR_GAIN_SETTING)
        |=> wb_dat_o == {24'h00_0000, gain_setting_r})
        else $error("gain readback wrong");
    AST_GAIN_POW: assert property (@(posedge clk) disable iff (reset)
        $stable(gain_setting_r) |=> decode_cfg.gain_factor ==
                                    (8'h01 << $past(gain_setting_r[2:0])))
        else $error("gain factor wrong");
    AST_AMP_ON: assert property (@(posedge clk) disable iff (reset)
        $stable(gain_setting_r) |=> decode_cfg.amp_enabled ==
                                    ($past(gain_setting_r[4:3]) == `AIGRC_AMP_ENABLED))
        else $error("amp enable decode wrong");
    AST_COMMON: assert property (@(posedge clk) disable iff (reset)
        $stable(input_select_r) |=> decode_cfg.positive_is_common ==
                                    ($past(input_select_r[7:4]) == `AIGRC_CODE_COMMON_INPUT))
        else $error("common input decode wrong");
    AST_RESTART: assert property (@(posedge clk) disable iff (reset)
        (wr_lane0 && wb_adr_i == `AIGRC_ADR_GAIN_SETTING && wbyte != gain_setting_r)
        |=> filter_restart)
        else $error("no restart on change");
endmodule

/* design/aigrc_start_delay.sv */
// Start delay counter run on the modulator clock enable
`timescale 1ns/10ps
`include "aigrc_defs.svh"
module aigrc_start_delay (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control
    input  wire logic       mod_tick,
    input  wire logic       restart,
    input  wire logic [2:0] delay_code,
    // Status
    output logic            delay_busy,
    output logic            start_conv
);
    logic [12:0] delay_cnt_r;
    logic [12:0] delay_load;

    always_comb begin
        unique case (delay_code)
            3'h0: delay_load = `AIGRC_DLY_CODE0;
            3'h1: delay_load = `AIGRC_DLY_CODE1;
            3'h2: delay_load = `AIGRC_DLY_CODE2;
            3'h3: delay_load = `AIGRC_DLY_CODE3;
            3'h4: delay_load = `AIGRC_DLY_CODE4;
            3'h5: delay_load = `AIGRC_DLY_CODE5;
            3'h6: delay_load = `AIGRC_DLY_CODE6;
            3'h7: delay_load = `AIGRC_DLY_CODE7;
        endcase
    end

    // Count modulator periods after a restart
    always_ff @(posedge clk) begin
        if (reset) begin
            delay_cnt_r <= 13'h0000;
        end else if (restart) begin
            delay_cnt_r <= delay_load;
        end else if (mod_tick && delay_cnt_r != 13'h0000) begin
            delay_cnt_r <= delay_cnt_r - 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            start_conv <= 1'b0;
        end else begin
            start_conv <= !restart && mod_tick && delay_cnt_r == 13'h0001;
        end
    end

    assign delay_busy = delay_cnt_r != 13'h0000;

    AST_DELAY_LOAD: assert property (@(posedge clk) disable iff (reset)
        restart |=> delay_cnt_r == $past(delay_load))
        else $error("start delay not loaded");
    AST_DELAY_DONE: assert property (@(posedge clk) disable iff (reset)
        (mod_tick && !restart && delay_cnt_r == 13'h0001) |=> start_conv && !delay_busy)
        else $error("start pulse missing at end of delay");
endmodule

/* tb/adc_input_gain_rate_config_regs_test.sv */
// Self-checking bench for the input, gain and rate configuration bank
`timescale 1ns/10ps
module adc_input_gain_rate_config_regs_test;
    import aigrc_pkg::*;
    logic             clk, reset, mod_tick, cyc, stb, we, ack;
    logic             filter_restart, start_conv, delay_busy;
    logic [7:0]       adr;
    logic [3:0]       sel;
    logic [31:0]      dat_w, dat_r, rd_q;
    aigrc_input_type  input_cfg;
    aigrc_gain_type   gain_cfg;
    aigrc_rate_type   rate_cfg;
    aigrc_decode_type decode_cfg;
    int               err_count = 0;
    int               comparisons = 0;
    int               cycles = 0;

    aigrc_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
                     .dat_w(dat_w), .dat_r(dat_r), .ack(ack));
    aigrc_regs uut (.clk(clk), .reset(reset), .mod_tick(mod_tick), .wb_cyc_i(cyc),
                    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
                    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
                    .input_cfg(input_cfg), .gain_cfg(gain_cfg), .rate_cfg(rate_cfg),
                    .decode_cfg(decode_cfg), .filter_restart(filter_restart),
                    .start_conv(start_conv), .delay_busy(delay_busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        $display("counts: %0d compared, %0d mismatched", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            $display("mismatch at %0t: timeout", $time);
            conclude;
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %b want %b", $time, m, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
        host.xfer(1'b0, a, 32'h0, rd_q);
        chk_val(rd_q[15:0], {8'h00, exp}, m);
    endtask

    // Write, then let restart and decode settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, rd_q);
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset;
        rd(8'h08, 8'h01, "input reset");
        rd(8'h0c, 8'h00, "gain reset");
        rd(8'h10, 8'h14, "rate reset");
        chk_val({8'h00, input_cfg}, 16'h0001, "input out");
        chk_flag(rate_cfg.single_shot_mode, 1'b0, "mode");
        chk_flag(rate_cfg.clock_source_ext, 1'b0, "clk src");
        chk_flag(rate_cfg.low_latency_filter, 1'b1, "filter");
        $display("test reset done");
    endtask

    task automatic t_input;
        wr(8'h08, 8'hc5);
        chk_flag(decode_cfg.positive_is_common, 1'b1, "pos com");
        chk_val({12'h0, input_cfg.negative_input_sel}, 16'h5, "neg sel");
        wr(8'h08, 8'hbd);
        rd(8'h08, 8'hbd, "input rsvd");
        chk_flag(decode_cfg.negative_reserved, 1'b1, "neg rsvd");
        chk_flag(decode_cfg.positive_reserved, 1'b0, "pos ch11");
        wr(8'h08, 8'hec);
        chk_flag(decode_cfg.negative_is_common, 1'b1, "neg com");
        chk_flag(decode_cfg.positive_reserved, 1'b1, "pos rsvd");
        $display("test input done");
    endtask

    task automatic t_gain;
        for (int g = 0; g < 8; g++) begin
            wr(8'h0c, {5'h01, g[2:0]});
            chk_val({8'h00, decode_cfg.gain_factor}, 16'h1 << g, "gain");
            chk_flag(decode_cfg.amp_enabled, 1'b1, "amp on");
        end
        wr(8'h0c, 8'h17);
        chk_flag(decode_cfg.amp_reserved, 1'b1, "amp rsvd");
        chk_val({8'h00, gain_cfg}, 16'h0017, "gain out");
        rd(8'h0c, 8'h17, "gain rsvd");
        wr(8'h0c, 8'h00);
        chk_flag(decode_cfg.amp_enabled, 1'b0, "bypass");
        $display("test gain done");
    endtask

    task automatic t_delay;
        int   dly [8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
        int   n;
        logic done;
        for (int c = 0; c < 8; c++) begin
            host.xfer(1'b1, 8'h0c, {24'h00_0000, c[2:0], 5'h09}, rd_q);
            chk_flag(filter_restart, 1'b1, "restart");
            n = 0;
            done = 1'b0;
            @(posedge clk);
            chk_flag(delay_busy, 1'b1, "busy");
            if (c == 0) begin
                rd(8'h14, 8'h01, "status busy");
            end
            while (!done && n < 5000) begin
                @(posedge clk);
                mod_tick <= 1'b1;
                @(posedge clk);
                mod_tick <= 1'b0;
                n++;
                @(posedge clk);
                done = (start_conv === 1'b1);
            end
            chk_val(n[15:0], dly[c][15:0], "delay ticks");
        end
        host.xfer(1'b1, 8'h0c, 32'h0000_00e9, rd_q);
        chk_flag(filter_restart, 1'b0, "no restart");
        @(posedge clk);
        chk_flag(delay_busy, 1'b0, "idle");
        rd(8'h14, 8'h00, "status idle");
        $display("test delay done");
    endtask

    task automatic t_rate;
        wr(8'h10, 8'heb);
        rd(8'h10, 8'heb, "rate rd");
        chk_flag(rate_cfg.global_chop_en, 1'b1, "chop");
        chk_flag(rate_cfg.single_shot_mode, 1'b1, "single");
        chk_flag(rate_cfg.clock_source_ext, 1'b1, "ext clk");
        chk_flag(rate_cfg.low_latency_filter, 1'b0, "sinc3");
        chk_val({12'h0, rate_cfg.output_rate_code}, 16'hb, "rate code");
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00, "unmapped");
        rd(8'h10, 8'heb, "rate kept");
        $display("test rate done");
    endtask

    initial begin
        reset    = 1'b1;
        mod_tick = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_input;
        t_gain;
        t_delay;
        t_rate;
        conclude;
    end
endmodule

/* tb/aigrc_host.sv */
// Wishbone master model standing in for the host controller
`timescale 1ns/10ps
module aigrc_host (
    // Clock
    input  wire logic        clk,
    // Wishbone request
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat_w,
    // Wishbone answer
    input  wire logic [31:0] dat_r,
    input  wire logic        ack
);
    initial begin
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 8'h00;
        sel   = 4'h0;
        dat_w = 32'h0;
    end
    // Channel codes chosen by caller, twelve-channel part
    // Bypass writes carry gain 000 from caller
    // One classic cycle, held until ack
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'h1;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
endmodule
